// >>> cmh_pkg.sv
`default_nettype none
package cmh_pkg;
  localparam int NUM_OBJ = 32;
  // Register byte offsets
  localparam logic [11:0] OFS_CTL = 12'h000;
  localparam logic [11:0] OFS_STS = 12'h004;
  localparam logic [11:0] OFS_BIT = 12'h00C;
  localparam logic [11:0] OFS_BRPE = 12'h018;
  localparam logic [11:0] OFS_TXRQ1 = 12'h100;
  localparam logic [11:0] OFS_TXRQ2 = 12'h104;
  localparam logic [11:0] OFS_NWDA1 = 12'h120;
  localparam logic [11:0] OFS_NWDA2 = 12'h124;
  // Interface sets sit on 64-byte pages, registers at offsets inside the page
  localparam logic [5:0] IF1_PAGE = 6'h01;
  localparam logic [5:0] IF2_PAGE = 6'h02;
  localparam logic [5:0] IF_CRQ = 6'h00;
  localparam logic [5:0] IF_CMSK = 6'h04;
  localparam logic [5:0] IF_MSK1 = 6'h08;
  localparam logic [5:0] IF_MSK2 = 6'h0C;
  localparam logic [5:0] IF_ARB1 = 6'h10;
  localparam logic [5:0] IF_ARB2 = 6'h14;
  localparam logic [5:0] IF_MCTL = 6'h18;
  localparam logic [5:0] IF_DA1 = 6'h1C;
  localparam logic [5:0] IF_DA2 = 6'h20;
  localparam logic [5:0] IF_DB1 = 6'h24;
  localparam logic [5:0] IF_DB2 = 6'h28;
  // Field positions
  localparam int CTL_INIT = 0;
  localparam int CTL_CCE = 6;
  localparam int STS_BOFF = 7;
  localparam int STS_JOINED = 4;
  localparam int CRQ_BUSY = 15;
  localparam int CM_WR = 7;
  localparam int CM_MASK = 6;
  localparam int CM_ARB = 5;
  localparam int CM_CTRL = 4;
  localparam int CM_CLRINT = 3;
  localparam int CM_NDTX = 2;
  localparam int CM_DA = 1;
  localparam int CM_DB = 0;
  localparam int A2_VALID = 15;
  localparam int A2_XTD = 14;
  localparam int A2_DIR = 13;
  localparam int MK_MASK_EXTENDED_ONLY = 15;
  localparam int MC_FRESH_DATA_FLAG = 15;
  localparam int MC_LOST = 14;
  localparam int MC_OBJECT_IRQ_PENDING = 13;
  localparam int MC_USE_ACCEPT_MASK = 12;
  localparam int MC_TX_DONE_IRQ_ENABLE = 11;
  localparam int MC_RX_IRQ_ENABLE = 10;
  localparam int MC_REMOTE_ANSWER_ENABLE = 9;
  localparam int MC_TRANSMIT_REQUEST = 8;
  // Reset values and limits
  localparam logic [15:0] BIT_RST = 16'h2301;
  localparam logic [3:0] BRPE_RST = 4'h0;
  localparam logic [8:0] TEC_LIMIT = 9'h0FF;
  localparam logic [3:0] IDLE_BITS = 4'hB;
  localparam logic [28:0] STD_ID_MASK = 29'h1FFC0000;
  typedef struct packed {
    logic [15:0] arb2, arb1, msk2, msk1, mctl, da1, da2, db1, db2;
  } cmh_obj_s;
  typedef struct packed {
    logic xtd;
    logic rtr;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmh_frame_s;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} cmh_tx_e;
endpackage
`default_nettype wire

// >>> cmh_can_handler.sv
// Overview of operation
// - Init on software, reset, or bus-off
// - Init halts transfers, transmit pin recessive
// - Init leaves configuration, objects, counters alone
// - Timing registers writable only with init and enable
// - Wait 11 recessive bits before joining bus
// - 32 objects reached only via interface sets
// - Two independent interface sets, transfers queued
// - Concurrent host and bus updates stay consistent
// - Store accepted frame whole into object
// - Start highest-priority request when idle, clear fresh
// - Clear request only if no new data
// - Set pending after success when enabled
// - Retry after loss or error, priority order
// - Updated data before start replaces old
// - Matching remote frame sets transmit request
// - Mask enable and extended-only remote filtering
// - Standard identifier uses arbitration bits 12:2
// - Fresh flag with request; cleared at start
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cmh_can_handler (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN pins
  input wire logic can_rx,
  output logic can_tx,
  // Protocol core
  input wire logic core_tx_ready,
  input wire logic core_tx_bit,
  input wire logic core_tx_done,
  input wire logic core_tx_err,
  input wire logic [8:0] core_tx_err_count,
  input wire logic core_rx_valid,
  input wire cmh_pkg::cmh_frame_s core_rx_frame,
  output logic core_tx_start,
  output var cmh_pkg::cmh_frame_s core_tx_frame,
  output logic bus_active
);

  function automatic logic [5:0] first_set(logic [31:0] v);
    first_set = 6'h00;
    for (int k = 31; k >= 0; k--) begin
      if (v[k]) first_set = {1'b1, 5'(k)};
    end
  endfunction

  function automatic logic obj_match(cmh_pkg::cmh_obj_s o, cmh_pkg::cmh_frame_s f);
    logic [28:0] oid;
    logic [28:0] msk;
    logic xok;
    oid = {o.arb2[12:0], o.arb1};
    msk = o.mctl[cmh_pkg::MC_USE_ACCEPT_MASK] ? {o.msk2[12:0], o.msk1} : 29'h1FFFFFFF;
    if (!f.xtd) msk = msk & cmh_pkg::STD_ID_MASK;
    if (o.mctl[cmh_pkg::MC_USE_ACCEPT_MASK] && o.msk2[cmh_pkg::MK_MASK_EXTENDED_ONLY]) xok = f.xtd;
    else xok = (o.arb2[cmh_pkg::A2_XTD] == f.xtd);
    obj_match = o.arb2[cmh_pkg::A2_VALID] && (((oid ^ f.id) & msk) == 29'h0) && xok &&
      (o.arb2[cmh_pkg::A2_DIR] == f.rtr);
  endfunction

  function automatic logic [15:0] if_read(cmh_pkg::cmh_obj_s o, logic [7:0] cm, logic b,
                                          logic [5:0] n, logic [5:0] ofs);
    case (ofs)
      cmh_pkg::IF_CRQ: if_read = {b, 9'h000, n};
      cmh_pkg::IF_CMSK: if_read = {8'h00, cm};
      cmh_pkg::IF_MSK1: if_read = o.msk1;
      cmh_pkg::IF_MSK2: if_read = o.msk2;
      cmh_pkg::IF_ARB1: if_read = o.arb1;
      cmh_pkg::IF_ARB2: if_read = o.arb2;
      cmh_pkg::IF_MCTL: if_read = o.mctl;
      cmh_pkg::IF_DA1: if_read = o.da1;
      cmh_pkg::IF_DA2: if_read = o.da2;
      cmh_pkg::IF_DB1: if_read = o.db1;
      cmh_pkg::IF_DB2: if_read = o.db2;
      default: if_read = 16'h0000;
    endcase
  endfunction

  // Bus slave: writes land in the data phase, reads add one wait state
  // so a read right after a write sees the written value.
  logic dp_wr, rd_pend;
  logic [11:0] dp_addr;
  logic [31:0] rd_value;
  wire accept = hsel & hready & htrans[1];
  wire [15:0] wd = hwdata[15:0];
  wire wr_ctl = dp_wr && dp_addr == cmh_pkg::OFS_CTL;
  wire wr_bit = dp_wr && dp_addr == cmh_pkg::OFS_BIT;
  wire wr_brpe = dp_wr && dp_addr == cmh_pkg::OFS_BRPE;
  wire [1:0] wr_if = {dp_wr && dp_addr[11:6] == cmh_pkg::IF2_PAGE,
                      dp_wr && dp_addr[11:6] == cmh_pkg::IF1_PAGE};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      if (accept) dp_addr <= haddr;
      dp_wr <= accept & hwrite;
      rd_pend <= accept & ~hwrite;
      if (rd_pend) hrdata <= rd_value;
    end
  end
  assign hreadyout = ~rd_pend;
  assign hresp = 1'b0;

  // Control, timing and bus-off
  logic ctl_init, ctl_cce, sts_boff;
  logic [15:0] bit_timing_reg;
  logic [3:0] prescaler_ext_reg;
  wire busoff = core_tx_err_count > cmh_pkg::TEC_LIMIT;
  wire cfg_open = ctl_init & ctl_cce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_init <= 1'b1;
      ctl_cce <= 1'b0;
      sts_boff <= 1'b0;
      bit_timing_reg <= cmh_pkg::BIT_RST;
      prescaler_ext_reg <= cmh_pkg::BRPE_RST;
    end else begin
      // Bus-off wins over a software clear in the same cycle
      if (busoff) ctl_init <= 1'b1;
      else if (wr_ctl) ctl_init <= wd[cmh_pkg::CTL_INIT];
      if (wr_ctl) ctl_cce <= wd[cmh_pkg::CTL_CCE];
      if (busoff) sts_boff <= 1'b1;
      else if (wr_ctl && !wd[cmh_pkg::CTL_INIT]) sts_boff <= 1'b0;
      if (wr_bit && cfg_open) bit_timing_reg <= wd;
      if (wr_brpe && cfg_open) prescaler_ext_reg <= wd[3:0];
    end
  end

  // Bit timing and bus idle detection
  logic rx_s1, rx_s2, rx_s3, rx_f, joined;
  logic [9:0] q_cnt;
  logic [4:0] tq_cnt;
  logic [3:0] rec_cnt;
  wire [9:0] q_max = {prescaler_ext_reg, bit_timing_reg[5:0]};
  wire [4:0] tq_max = 5'(bit_timing_reg[11:8]) + 5'(bit_timing_reg[14:12]) + 5'h02;
  wire bit_tick = (q_cnt == q_max) && (tq_cnt == tq_max);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rx_s1, rx_s2, rx_s3, rx_f} <= 4'hF;
      q_cnt <= 10'h000;
      tq_cnt <= 5'h00;
      rec_cnt <= 4'h0;
      joined <= 1'b0;
      can_tx <= 1'b1;
    end else begin
      rx_s1 <= can_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_f <= rx_s3;
      // Bit timer restarts in init so bus idle counts whole bits only
      q_cnt <= (q_cnt == q_max || ctl_init) ? 10'h000 : q_cnt + 10'h001;
      if (ctl_init) tq_cnt <= 5'h00;
      else if (q_cnt == q_max) tq_cnt <= (tq_cnt == tq_max) ? 5'h00 : tq_cnt + 5'h01;
      if (ctl_init) begin
        rec_cnt <= 4'h0;
        joined <= 1'b0;
      end else if (bit_tick && !joined) begin
        rec_cnt <= rx_f ? rec_cnt + 4'h1 : 4'h0;
        joined <= rx_f && (rec_cnt == cmh_pkg::IDLE_BITS - 4'h1);
      end
      can_tx <= bus_active ? core_tx_bit : 1'b1;
    end
  end
  assign bus_active = joined & ~ctl_init;

  // Message objects: not mapped, reached only through the interface sets
  cmh_pkg::cmh_obj_s mem [cmh_pkg::NUM_OBJ];
  cmh_pkg::cmh_obj_s ifo [2];
  logic [7:0] ifcm [2];
  logic [5:0] ifnum [2];
  logic [1:0] ifbusy;
  logic [31:0] dirty;
  logic [31:0] txreq, rxhit, txrq_sum, nd_sum;
  logic mem_we;
  logic [4:0] mem_idx;
  cmh_pkg::cmh_obj_s mem_wd, merged, rx_new;

  for (genvar g = 0; g < cmh_pkg::NUM_OBJ; g++) begin : g_obj
    assign txreq[g] = mem[g].arb2[cmh_pkg::A2_VALID] & mem[g].arb2[cmh_pkg::A2_DIR] &
                      mem[g].mctl[cmh_pkg::MC_TRANSMIT_REQUEST];
    assign txrq_sum[g] = mem[g].mctl[cmh_pkg::MC_TRANSMIT_REQUEST];
    assign nd_sum[g] = mem[g].mctl[cmh_pkg::MC_FRESH_DATA_FLAG];
  end

  // One transfer per cycle, set 1 first; the other set waits its turn
  wire xfer_go = |ifbusy;
  wire xi = ~ifbusy[0];
  wire [5:0] xnum = ifnum[xi];
  wire xnum_ok = (xnum != 6'h00) && (xnum <= 6'h20);
  wire [4:0] xidx = 5'(xnum - 6'h01);
  wire [7:0] xcm = ifcm[xi];
  wire xwr = xcm[cmh_pkg::CM_WR];
  wire xdata = xcm[cmh_pkg::CM_DA] | xcm[cmh_pkg::CM_DB] | xcm[cmh_pkg::CM_NDTX];
  cmh_pkg::cmh_obj_s cur_x;
  assign cur_x = mem[xidx];

  always_comb begin
    merged = cur_x;
    if (xwr) begin
      if (xcm[cmh_pkg::CM_MASK]) {merged.msk2, merged.msk1} = {ifo[xi].msk2, ifo[xi].msk1};
      if (xcm[cmh_pkg::CM_ARB]) {merged.arb2, merged.arb1} = {ifo[xi].arb2, ifo[xi].arb1};
      if (xcm[cmh_pkg::CM_CTRL]) merged.mctl = ifo[xi].mctl;
      if (xcm[cmh_pkg::CM_DA]) {merged.da2, merged.da1} = {ifo[xi].da2, ifo[xi].da1};
      if (xcm[cmh_pkg::CM_DB]) {merged.db2, merged.db1} = {ifo[xi].db2, ifo[xi].db1};
      if (xcm[cmh_pkg::CM_NDTX]) begin
        merged.mctl[cmh_pkg::MC_TRANSMIT_REQUEST] = 1'b1;
        merged.mctl[cmh_pkg::MC_FRESH_DATA_FLAG] = 1'b1;
      end
    end else if (xcm[cmh_pkg::CM_NDTX]) begin
      merged.mctl[cmh_pkg::MC_FRESH_DATA_FLAG] = 1'b0;
    end
    if (xcm[cmh_pkg::CM_CLRINT]) merged.mctl[cmh_pkg::MC_OBJECT_IRQ_PENDING] = 1'b0;
  end

  // Interface register sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        ifo[i] <= '0;
        ifcm[i] <= 8'h00;
        ifnum[i] <= 6'h01;
      end
      ifbusy <= 2'b00;
    end else begin
      // Writes to a set that is busy are dropped
      for (int i = 0; i < 2; i++) begin
        if (wr_if[i] && !ifbusy[i]) begin
          case (dp_addr[5:0])
            cmh_pkg::IF_CRQ: begin
              ifnum[i] <= wd[5:0];
              ifbusy[i] <= 1'b1;
            end
            cmh_pkg::IF_CMSK: ifcm[i] <= wd[7:0];
            cmh_pkg::IF_MSK1: ifo[i].msk1 <= wd;
            cmh_pkg::IF_MSK2: ifo[i].msk2 <= wd;
            cmh_pkg::IF_ARB1: ifo[i].arb1 <= wd;
            cmh_pkg::IF_ARB2: ifo[i].arb2 <= wd;
            cmh_pkg::IF_MCTL: ifo[i].mctl <= wd;
            cmh_pkg::IF_DA1: ifo[i].da1 <= wd;
            cmh_pkg::IF_DA2: ifo[i].da2 <= wd;
            cmh_pkg::IF_DB1: ifo[i].db1 <= wd;
            cmh_pkg::IF_DB2: ifo[i].db2 <= wd;
            default: ;
          endcase
        end
      end
      if (xfer_go) begin
        ifbusy[xi] <= 1'b0;
        if (!xwr && xnum_ok) ifo[xi] <= cur_x;
      end
    end
  end

  // Bus-side events wait while a transfer owns the memory port
  cmh_pkg::cmh_tx_e tx_st;
  cmh_pkg::cmh_frame_s rx_buf;
  logic rx_pend, done_pend;
  logic [4:0] tx_obj;
  wire [5:0] tx_sel = first_set(txreq);
  wire [5:0] rx_sel = first_set(rxhit);
  cmh_pkg::cmh_obj_s rx_old, tx_old, sel_obj;
  assign rx_old = mem[rx_sel[4:0]];
  assign tx_old = mem[tx_obj];
  assign sel_obj = mem[tx_sel[4:0]];
  wire rx_do = rx_pend & ~xfer_go;
  wire done_do = done_pend & ~xfer_go & ~rx_pend;
  wire start_do = (tx_st == cmh_pkg::TX_IDLE) & core_tx_ready & bus_active & tx_sel[5] &
                  ~xfer_go & ~rx_pend & ~done_pend;

  for (genvar g = 0; g < cmh_pkg::NUM_OBJ; g++) begin : g_hit
    assign rxhit[g] = obj_match(mem[g], rx_buf);
  end

  always_comb begin
    rx_new = rx_old;
    if (!rx_buf.rtr || (!rx_old.mctl[cmh_pkg::MC_REMOTE_ANSWER_ENABLE] && rx_old.mctl[cmh_pkg::MC_USE_ACCEPT_MASK])) begin
      rx_new.arb2[cmh_pkg::A2_XTD] = rx_buf.xtd;
      rx_new.arb2[12:0] = rx_buf.xtd ? rx_buf.id[28:16] : {rx_buf.id[28:18], 2'b00};
      rx_new.arb1 = rx_buf.xtd ? rx_buf.id[15:0] : 16'h0000;
      rx_new.mctl[3:0] = rx_buf.dlc;
      rx_new.mctl[cmh_pkg::MC_FRESH_DATA_FLAG] = 1'b1;
      rx_new.mctl[cmh_pkg::MC_LOST] = rx_old.mctl[cmh_pkg::MC_FRESH_DATA_FLAG];
      if (rx_buf.rtr) begin
        rx_new.mctl[cmh_pkg::MC_TRANSMIT_REQUEST] = 1'b0;
      end else begin
        {rx_new.db2, rx_new.db1, rx_new.da2, rx_new.da1} = rx_buf.data;
        if (rx_old.mctl[cmh_pkg::MC_RX_IRQ_ENABLE]) rx_new.mctl[cmh_pkg::MC_OBJECT_IRQ_PENDING] = 1'b1;
      end
    end else if (rx_old.mctl[cmh_pkg::MC_REMOTE_ANSWER_ENABLE]) begin
      rx_new.mctl[cmh_pkg::MC_TRANSMIT_REQUEST] = 1'b1;
    end
  end

  // Single memory write port, fixed priority keeps every update whole
  always_comb begin
    mem_we = 1'b0;
    mem_idx = xidx;
    mem_wd = merged;
    if (xfer_go) begin
      mem_we = xnum_ok;
    end else if (rx_pend) begin
      mem_we = rx_sel[5];
      mem_idx = rx_sel[4:0];
      mem_wd = rx_new;
    end else if (done_pend) begin
      mem_we = 1'b1;
      mem_idx = tx_obj;
      mem_wd = tx_old;
      if (!dirty[tx_obj]) mem_wd.mctl[cmh_pkg::MC_TRANSMIT_REQUEST] = 1'b0;
      if (tx_old.mctl[cmh_pkg::MC_TX_DONE_IRQ_ENABLE]) mem_wd.mctl[cmh_pkg::MC_OBJECT_IRQ_PENDING] = 1'b1;
    end else if (start_do) begin
      mem_we = 1'b1;
      mem_idx = tx_sel[4:0];
      mem_wd = sel_obj;
      mem_wd.mctl[cmh_pkg::MC_FRESH_DATA_FLAG] = 1'b0;
    end
  end

  // Object contents keep their value through init and have no reset
  always_ff @(posedge hclk) begin
    if (mem_we) mem[mem_idx] <= mem_wd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= cmh_pkg::TX_IDLE;
      rx_pend <= 1'b0;
      done_pend <= 1'b0;
      rx_buf <= '0;
      tx_obj <= 5'h00;
      dirty <= 32'h00000000;
      core_tx_start <= 1'b0;
      core_tx_frame <= '0;
    end else begin
      core_tx_start <= start_do;
      if (core_rx_valid && bus_active) begin
        rx_buf <= core_rx_frame;
        rx_pend <= 1'b1;
      end else if (rx_do) begin
        rx_pend <= 1'b0;
      end
      if (xfer_go && xnum_ok && xwr && xdata) dirty[xidx] <= 1'b1;
      case (tx_st)
        cmh_pkg::TX_IDLE: begin
          if (start_do) begin
            tx_st <= cmh_pkg::TX_BUSY;
            tx_obj <= tx_sel[4:0];
            dirty[tx_sel[4:0]] <= 1'b0;
            core_tx_frame <= {sel_obj.arb2[cmh_pkg::A2_XTD], 1'b0, sel_obj.arb2[12:0],
                              sel_obj.arb1, sel_obj.mctl[3:0],
                              sel_obj.db2, sel_obj.db1, sel_obj.da2, sel_obj.da1};
          end
        end
        cmh_pkg::TX_BUSY: begin
          // An error leaves the request set so the scan retries it by priority
          if (core_tx_done) done_pend <= 1'b1;
          else if (core_tx_err || ctl_init) tx_st <= cmh_pkg::TX_IDLE;
          if (done_do) begin
            done_pend <= 1'b0;
            tx_st <= cmh_pkg::TX_IDLE;
          end
        end
        default: tx_st <= cmh_pkg::TX_IDLE;
      endcase
    end
  end

  // Read data
  always_comb begin
    rd_value = 32'h00000000;
    case (dp_addr)
      cmh_pkg::OFS_CTL: rd_value[7:0] = {1'b0, ctl_cce, 5'h00, ctl_init};
      cmh_pkg::OFS_STS: rd_value[7:0] = {sts_boff, 2'b00, joined, 4'h0};
      cmh_pkg::OFS_BIT: rd_value[15:0] = bit_timing_reg;
      cmh_pkg::OFS_BRPE: rd_value[3:0] = prescaler_ext_reg;
      cmh_pkg::OFS_TXRQ1: rd_value[15:0] = txrq_sum[15:0];
      cmh_pkg::OFS_TXRQ2: rd_value[15:0] = txrq_sum[31:16];
      cmh_pkg::OFS_NWDA1: rd_value[15:0] = nd_sum[15:0];
      cmh_pkg::OFS_NWDA2: rd_value[15:0] = nd_sum[31:16];
      default: begin
        if (dp_addr[11:6] == cmh_pkg::IF1_PAGE)
          rd_value[15:0] = if_read(ifo[0], ifcm[0], ifbusy[0], ifnum[0], dp_addr[5:0]);
        else if (dp_addr[11:6] == cmh_pkg::IF2_PAGE)
          rd_value[15:0] = if_read(ifo[1], ifcm[1], ifbusy[1], ifnum[1], dp_addr[5:0]);
      end
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  busoff_init_a: assert property (busoff |=> ctl_init)
    else $error("bus-off did not force init");
  tx_recessive_a: assert property (ctl_init |=> can_tx)
    else $error("transmit pin driven during init");
  init_keeps_a: assert property ($rose(ctl_init) |-> $stable(bit_timing_reg))
    else $error("timing changed on entering init");
  timing_lock_a: assert property (wr_bit && !cfg_open |=> $stable(bit_timing_reg))
    else $error("timing register written while locked");
  idle_join_a: assert property ($rose(joined) |-> $past(rec_cnt) == 4'hA && !ctl_init)
    else $error("joined bus without eleven recessive bits");
  xfer_queue_a: assert property (ifbusy == 2'b11 |=> ifbusy == 2'b10)
    else $error("interface transfers not served in turn");
  start_fresh_a: assert property (start_do |=> core_tx_start && !mem[tx_obj].mctl[15])
    else $error("start did not clear fresh data flag");
  done_clear_a: assert property (done_do && !dirty[tx_obj] |=> !mem[tx_obj].mctl[8])
    else $error("request not cleared after success");
  done_irq_a: assert property (done_do && tx_old.mctl[11] |=> mem[tx_obj].mctl[13])
    else $error("pending flag not set after transmit");
  remote_ans_a: assert property (rx_do && rx_sel[5] && rx_buf.rtr && rx_old.mctl[9]
    |=> $past(rx_sel[4:0]) == rx_sel[4:0] && mem[rx_sel[4:0]].mctl[8])
    else $error("remote frame did not raise request");

  start_c: cover property (start_do ##[1:300] done_do);
  remote_c: cover property (rx_do && rx_buf.rtr && rx_sel[5]);
  both_if_c: cover property (ifbusy == 2'b11);
  join_c: cover property ($rose(joined));

endmodule
`default_nettype wire

// >>> cmh_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmh_core_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Handler side
  input wire logic core_tx_start,
  // Behaviour select
  input wire logic slow,
  input wire logic fail_first,
  // Answers
  output logic core_tx_ready,
  output logic core_tx_bit,
  output logic core_tx_done,
  output logic core_tx_err
);
  logic [6:0] cnt;
  logic busy;
  logic failed;
  logic [1:0] gap;
  wire logic lose_now = fail_first && !failed;
  // Idle gap stands in for the bus going free again
  assign core_tx_ready = !busy && gap == 2'h0;
  // Toggling bits while busy, so a stuck pin shows up
  assign core_tx_bit = busy ? cnt[0] : 1'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 7'h0;
      busy <= 1'h0;
      failed <= 1'h0;
      gap <= 2'h0;
      core_tx_done <= 1'h0;
      core_tx_err <= 1'h0;
    end else begin
      core_tx_done <= 1'h0;
      core_tx_err <= 1'h0;
      if (gap != 2'h0) gap <= gap - 2'h1;
      if (core_tx_start) begin
        busy <= 1'h1;
        cnt <= slow ? 7'h3C : 7'h06;
      end else if (busy && cnt != 7'h0) begin
        cnt <= cnt - 7'h1;
      end else if (busy) begin
        busy <= 1'h0;
        gap <= 2'h3;
        failed <= failed | fail_first;
        core_tx_err <= lose_now;
        core_tx_done <= !lose_now;
      end
    end
  end
endmodule
`default_nettype wire

// >>> can_message_handler_tx_tb.sv
`timescale 1ns/10ps
`default_nettype none
module can_message_handler_tx_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } cmh_row_s;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [8:0] core_tx_err_count = 9'h0;
  logic core_rx_valid = 1'h0;
  cmh_pkg::cmh_frame_s core_rx_frame = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic can_tx;
  logic core_tx_ready;
  logic core_tx_bit;
  logic core_tx_done;
  logic core_tx_err;
  logic core_tx_start;
  logic bus_active;
  cmh_pkg::cmh_frame_s core_tx_frame;
  cmh_pkg::cmh_frame_s sent[$];
  cmh_row_s rows[5];
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [31:0] q;
  cmh_can_handler i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .can_rx(1'h1), .can_tx(can_tx),
    .core_tx_ready(core_tx_ready), .core_tx_bit(core_tx_bit), .core_tx_done(core_tx_done),
    .core_tx_err(core_tx_err), .core_tx_err_count(core_tx_err_count),
    .core_rx_valid(core_rx_valid), .core_rx_frame(core_rx_frame), .core_tx_start(core_tx_start),
    .core_tx_frame(core_tx_frame), .bus_active(bus_active)
  );
  cmh_core_model i_core (
    .hclk(hclk), .hresetn(hresetn), .core_tx_start(core_tx_start), .slow(1'h1),
    .fail_first(1'h1), .core_tx_ready(core_tx_ready), .core_tx_bit(core_tx_bit),
    .core_tx_done(core_tx_done), .core_tx_err(core_tx_err)
  );
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (core_tx_start === 1'h1) sent.push_back(core_tx_frame);
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [98:0] e, input logic [98:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask
  // Ready is judged before the edge, so no race with the slave's flops
  task automatic wait_rdy();
    int k;
    k = 0;
    @(negedge hclk);
    while (hready !== 1'h1 && k < 50) begin
      k++;
      @(negedge hclk);
    end
    if (k >= 50) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic xfer(input logic [5:0] p, input logic [5:0] obj);
    bus(1'h1, {p, cmh_pkg::IF_CRQ}, {26'h0, obj});
    n = 0;
    do begin
      bus(1'h0, {p, cmh_pkg::IF_CRQ}, 32'h0);
      n++;
    end while (q[cmh_pkg::CRQ_BUSY] !== 1'h0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic cfg(input logic [5:0] p, input logic [5:0] obj, input logic [10:0] sid);
    bus(1'h1, {p, cmh_pkg::IF_ARB2}, {16'h0, 3'h5, sid, 2'h0});
    bus(1'h1, {p, cmh_pkg::IF_MCTL}, 32'h0A88);
    bus(1'h1, {p, cmh_pkg::IF_CMSK}, 32'h00B0);
    xfer(p, obj);
  endtask
  task automatic send(input logic [5:0] p, input logic [5:0] obj, input logic [63:0] d);
    bus(1'h1, {p, cmh_pkg::IF_CMSK}, 32'h0087);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, {p, cmh_pkg::IF_DA1 + 6'(4 * i)}, {16'h0, d[16*i +: 16]});
    end
    xfer(p, obj);
  endtask
  function automatic cmh_pkg::cmh_frame_s fr(input logic [10:0] sid, input logic [63:0] d);
    fr = {2'h0, sid, 18'h0, 4'h8, d};
  endfunction
  initial begin
    rows[0] = '{cmh_pkg::OFS_BIT, 32'h0101, 32'h2301};
    rows[1] = '{cmh_pkg::OFS_CTL, 32'h0041, 32'h0041};
    rows[2] = '{cmh_pkg::OFS_BIT, 32'h0101, 32'h0101};
    rows[3] = '{12'hFFC, 32'h1234, 32'h0000};
    rows[4] = '{12'h048, 32'hBEEF, 32'hBEEF};
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    foreach (rows[i]) begin
      bus(1'h1, rows[i].a, rows[i].d);
      bus(1'h0, rows[i].a, 32'h0);
      chk("register readback", rows[i].e, q);
    end
    // Unused objects marked invalid with cleared control, else summaries read unknown
    bus(1'h1, {cmh_pkg::IF1_PAGE, cmh_pkg::IF_CMSK}, 32'h00B0);
    for (int i = 3; i <= 32; i++) xfer(cmh_pkg::IF1_PAGE, 6'(i));
    // Both requests queued in init; nothing may leave before joining
    cfg(cmh_pkg::IF1_PAGE, 6'h01, 11'h123);
    cfg(cmh_pkg::IF2_PAGE, 6'h02, 11'h055);
    send(cmh_pkg::IF1_PAGE, 6'h01, 64'h8877665544332211);
    send(cmh_pkg::IF2_PAGE, 6'h02, 64'h0F0E0D0C0B0A0908);
    chk("starts during init", 99'h0, 99'(sent.size()));
    bus(1'h1, cmh_pkg::OFS_CTL, 32'h0000);
    n = 0;
    while (bus_active !== 1'h1 && n < 400) begin
      @(negedge hclk);
      n++;
    end
    chk("join after idle bits", 99'h1, 99'(n >= 88 && n < 400));
    if (n >= 400) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge hclk);
    send(cmh_pkg::IF2_PAGE, 6'h02, 64'hCAFE0123BEEF4567);
    n = 0;
    while (sent.size() < 3 && n < 1000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 1000) begin
      miscompares++;
      tally_and_finish();
    end
    chk("first frame", fr(11'h123, 64'h8877665544332211), sent[0]);
    chk("retry frame", fr(11'h123, 64'h8877665544332211), sent[1]);
    chk("updated frame", fr(11'h055, 64'hCAFE0123BEEF4567), sent[2]);
    repeat (70) @(posedge hclk);
    bus(1'h0, cmh_pkg::OFS_TXRQ1, 32'h0);
    chk("requests after done", 99'h0, q);
    bus(1'h0, cmh_pkg::OFS_NWDA1, 32'h0);
    chk("fresh flags after start", 99'h0, q);
    bus(1'h1, {cmh_pkg::IF1_PAGE, cmh_pkg::IF_CMSK}, 32'h0010);
    xfer(cmh_pkg::IF1_PAGE, 6'h01);
    bus(1'h0, {cmh_pkg::IF1_PAGE, cmh_pkg::IF_MCTL}, 32'h0);
    chk("object control", 99'h2A88, q);
    // Remote request matching object 2 must queue it again
    core_rx_frame <= {2'h1, 11'h055, 18'h0, 4'h0, 64'h0};
    core_rx_valid <= 1'h1;
    @(posedge hclk);
    core_rx_valid <= 1'h0;
    repeat (70) @(posedge hclk);
    chk("frames after remote", 99'h4, 99'(sent.size()));
    chk("remote answer", fr(11'h055, 64'hCAFE0123BEEF4567), sent[3]);
    // Error count past the limit must force init
    core_tx_err_count <= 9'h100;
    repeat (3) @(posedge hclk);
    bus(1'h0, cmh_pkg::OFS_CTL, 32'h0);
    chk("init on bus-off", 99'h1, q[cmh_pkg::CTL_INIT]);
    chk("pin and activity", 99'h2, {can_tx, bus_active});
    bus(1'h0, cmh_pkg::OFS_BIT, 32'h0);
    chk("timing kept", 99'h0101, q);
    hresetn <= 1'h0;
    core_tx_err_count <= 9'h0;
    repeat (3) @(posedge hclk);
    chk("pins in reset", 99'h4, {can_tx, core_tx_start, bus_active});
    hresetn <= 1'h1;
    bus(1'h0, cmh_pkg::OFS_BIT, 32'h0);
    chk("timing after reset", 99'h2301, q);
    bus(1'h0, cmh_pkg::OFS_CTL, 32'h0);
    chk("init after reset", 99'h1, q[cmh_pkg::CTL_INIT]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
